// *** verilog/usb_pingpong_bd_irq.sv ***
/*
 * USB descriptor table, ping-pong pointer tracking, transfer status queue
 * and two-layer interrupt aggregation, with an APB register slave.
 * Assumes the serial engine presents tokens and completions as one-cycle
 * pulses synchronous to clk_i, and honours done_ready_o.
 */
`timescale 1ns/1ps
`default_nettype none

module usb_pingpong_bd_irq
	import usb_pp_pkg::*;
#(
	parameter int DEPTH = 4
)
(
	input  wire logic        clk_i,          // 40 MHz clock
	input  wire logic        rst_i,          // Async reset, active high
	input  wire logic        psel_i,         // APB select
	input  wire logic        penable_i,      // APB enable
	input  wire logic        pwrite_i,       // APB write
	input  wire logic [11:0] paddr_i,        // APB byte address
	input  wire logic [31:0] pwdata_i,       // APB write data
	input  wire logic [3:0]  pstrb_i,        // APB byte strobes
	output logic             pready_o,       // APB ready
	output logic [31:0]      prdata_o,       // APB read data
	output logic             pslverr_o,      // APB error
	input  wire logic        tok_valid_i,    // Token received, fetch descriptor
	input  wire logic [2:0]  tok_ep_i,       // Token endpoint
	input  wire logic        tok_in_i,       // Token direction is IN
	output logic             bd_valid_o,     // Fetch result pulse
	output logic [4:0]       bd_index_o,     // Descriptor index
	output logic [6:0]       bd_byte_addr_o, // Descriptor byte offset
	output logic             bd_owned_o,     // Engine owns descriptor
	output logic             bd_stall_o,     // Stall enable
	output logic             bd_toggle_check_o, // Toggle sync enabled
	output logic             bd_expected_toggle_o, // Expected toggle
	output logic [9:0]       bd_count_o,     // Byte count
	output logic [15:0]      bd_buf_addr_o,  // Buffer address
	input  wire logic        done_valid_i,   // Transaction complete
	input  wire logic [2:0]  done_ep_i,      // Completed endpoint
	input  wire logic        done_in_i,      // Completed direction is IN
	input  wire logic [3:0]  done_pid_i,     // Token PID
	input  wire logic [9:0]  done_count_i,   // Bytes moved
	output logic             done_ready_o,   // Completion accepted
	input  wire logic        sof_i,          // Start-of-frame event
	input  wire logic        stall_sent_i,   // Stall handshake event
	input  wire logic        idle_i,         // Idle detected event
	input  wire logic        activity_i,     // Bus activity event
	input  wire logic        bus_reset_i,    // USB reset event
	input  wire logic [7:0]  err_event_i,    // Error condition events
	output logic             usb_irq_o       // Aggregated interrupt request
);

	// ----------------------------------------------------------------
	// Parameters and state
	// ----------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_chk
		$error("DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [NUM_BD-1:0][31:0]      bd;
		logic [DEPTH-1:0][5:0]        fq;
		logic [AW-1:0]                rp;
		logic [AW-1:0]                wp;
		logic [CW-1:0]                cnt;
		logic [2*NUM_EP-1:0]          ptr;
		pp_mode_t                     mode;
		logic                         ptr_rst;
		logic                         enable;
		logic [6:0]                   sflag;
		logic [6:0]                   sen;
		logic [7:0]                   eflag;
		logic [7:0]                   een;
		logic                         irq;
		logic                         pready;
		logic [31:0]                  prdata;
		logic                         pslverr;
		logic                         done_ready;
		logic                         bd_valid;
		logic [4:0]                   bd_idx;
		logic                         own;
		logic                         stall;
		logic                         tsync;
		logic                         etog;
		logic [9:0]                   count;
		logic [15:0]                  bufaddr;
	} state_t;

	state_t              s_q;
	state_t              s_d;
	logic                apb_acc;
	logic                wr_go;
	logic                hit;
	logic [31:0]         rd_val;
	logic [3:0]          tok_key;
	logic [3:0]          done_key;
	logic [5:0]          tok_map;
	logic [5:0]          done_map;
	logic                done_take;
	logic                ptr_clear;
	logic                push;
	logic                pop;
	logic                flag_wr;
	logic [2*NUM_EP-1:0] ptr_nx;

	// ----------------------------------------------------------------
	// Decode and descriptor mapping
	// ----------------------------------------------------------------
	assign apb_acc   = psel_i & penable_i;
	assign wr_go     = apb_acc & s_q.pready & pwrite_i & hit;
	assign flag_wr   = wr_go & (paddr_i == ADDR_SFLAG);
	assign tok_key   = {tok_ep_i, tok_in_i};
	assign done_key  = {done_ep_i, done_in_i};
	assign tok_map   = bd_map(s_q.mode, tok_ep_i, tok_in_i, s_q.ptr[tok_key]);
	assign done_map  = bd_map(s_q.mode, done_ep_i, done_in_i, s_q.ptr[done_key]);
	assign done_take = done_valid_i & s_q.enable & s_q.done_ready;
	assign push      = done_take & (done_pid_i == PID_OUT || done_pid_i == PID_IN
		|| done_pid_i == PID_SETUP);
	assign pop       = flag_wr & s_q.sflag[FL_TRN] & ~pwdata_i[FL_TRN] & (s_q.cnt != '0);
	assign ptr_clear = s_q.ptr_rst | (wr_go & (paddr_i == ADDR_CONFIG)
		& pwdata_i[CFG_ENABLE] & ~s_q.enable);

	always_comb
	begin
		hit    = 1'b1;
		rd_val = RST_REG;
		if (paddr_i[11:7] == BD_REGION && paddr_i[1:0] == 2'b00)
			rd_val = s_q.bd[paddr_i[6:2]];
		else
		begin
			unique case (paddr_i)
				ADDR_CONFIG:  rd_val = {28'h0, s_q.enable, s_q.ptr_rst, s_q.mode};
				ADDR_XFER_ST: rd_val = (s_q.cnt == '0) ? RST_REG
					: {25'h0, s_q.fq[s_q.rp], 1'b0};
				ADDR_SFLAG:   rd_val = {25'h0, s_q.sflag};
				ADDR_SEN:     rd_val = {25'h0, s_q.sen};
				ADDR_EFLAG:   rd_val = {24'h0, s_q.eflag};
				ADDR_EEN:     rd_val = {24'h0, s_q.een};
				ADDR_IRQ_ST:  rd_val = {31'h0, s_q.irq};
				default:      hit = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Ping-pong pointers
	// ----------------------------------------------------------------
	for (genvar k = 0; k < 2 * NUM_EP; k++)
	begin : g_ptr
		assign ptr_nx[k] = ptr_clear ? 1'b0
			: (done_take && done_map[5] && done_key == 4'(k)) ? ~s_q.ptr[k]
			: s_q.ptr[k];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [6:0] sw;
		s_d          = s_q;
		sw           = flag_wr ? pwdata_i[6:0] : s_q.sflag;
		s_d.bd_valid = 1'b0;
		s_d.ptr      = ptr_nx;

		s_d.pready  = apb_acc & ~s_q.pready;
		s_d.pslverr = apb_acc & ~s_q.pready & ~hit;
		if (apb_acc && !s_q.pready)
			s_d.prdata = pwrite_i ? RST_REG : rd_val;

		if (wr_go)
		begin
			if (paddr_i[11:7] == BD_REGION)
			begin
				for (int b = 0; b < BD_BYTES; b++)
					if (pstrb_i[b])
						s_d.bd[paddr_i[6:2]][8*b +: 8] = pwdata_i[8*b +: 8];
			end
			unique case (paddr_i)
				ADDR_CONFIG:
				begin
					s_d.mode    = pp_mode_t'(pwdata_i[CFG_MODE_LSB +: 2]);
					s_d.ptr_rst = pwdata_i[CFG_PTR_RST];
					s_d.enable  = pwdata_i[CFG_ENABLE];
				end
				ADDR_SEN: s_d.sen = pwdata_i[6:0];
				ADDR_EEN: s_d.een = pwdata_i[7:0];
				default:  ;
			endcase
		end

		// Flags: events win over a clearing write
		s_d.sflag              = sw;
		s_d.sflag[FL_SOF]      = sw[FL_SOF] | sof_i;
		s_d.sflag[FL_STALL]    = sw[FL_STALL] | stall_sent_i;
		s_d.sflag[FL_IDLE]     = sw[FL_IDLE] | idle_i;
		s_d.sflag[FL_ACTIVITY] = sw[FL_ACTIVITY] | activity_i;
		s_d.sflag[FL_RESET]    = sw[FL_RESET] | bus_reset_i;
		s_d.sflag[FL_TRN]      = push | (pop ? (s_q.cnt > CW'(1)) : sw[FL_TRN]);
		s_d.sflag[FL_ERR]      = |(s_q.eflag & s_q.een);
		s_d.eflag = ((wr_go && paddr_i == ADDR_EFLAG) ? pwdata_i[7:0] : s_q.eflag)
			| err_event_i;
		s_d.irq = |(s_q.sflag & s_q.sen);

		// Descriptor fetch for a token
		if (tok_valid_i && s_q.enable)
		begin
			s_d.bd_valid = 1'b1;
			s_d.bd_idx   = tok_map[4:0];
			s_d.own      = s_q.bd[tok_map[4:0]][ST_OWN];
			s_d.stall    = s_q.bd[tok_map[4:0]][ST_BUFFER_STALL_ENABLE];
			s_d.tsync    = s_q.bd[tok_map[4:0]][ST_TSYNC];
			s_d.etog     = s_q.bd[tok_map[4:0]][ST_ETOG] & s_q.bd[tok_map[4:0]][ST_TSYNC];
			s_d.count    = {s_q.bd[tok_map[4:0]][1:0], s_q.bd[tok_map[4:0]][15:8]};
			s_d.bufaddr  = s_q.bd[tok_map[4:0]][31:16];
		end

		// Completion: return descriptor to firmware, engine write wins
		if (done_take)
		begin
			s_d.bd[done_map[4:0]][15:0] = {done_count_i[7:0], 1'b0,
				s_q.bd[done_map[4:0]][ST_ETOG], done_pid_i, done_count_i[9:8]};
		end

		// Transfer status queue
		if (push)
		begin
			s_d.fq[s_q.wp] = {1'b0, done_ep_i, done_in_i, s_q.ptr[done_key]};
			s_d.wp         = s_q.wp + AW'(1);
		end
		if (pop)
			s_d.rp = s_q.rp + AW'(1);
		s_d.cnt        = s_q.cnt + CW'(push) - CW'(pop);
		s_d.done_ready = s_d.cnt < CW'(DEPTH);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q            <= '0;
			s_q.done_ready <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pready_o             = s_q.pready;
	assign prdata_o             = s_q.prdata;
	assign pslverr_o            = s_q.pslverr;
	assign bd_valid_o           = s_q.bd_valid;
	assign bd_index_o           = s_q.bd_idx;
	assign bd_byte_addr_o       = {s_q.bd_idx, 2'b00};
	assign bd_owned_o           = s_q.own;
	assign bd_stall_o           = s_q.stall;
	assign bd_toggle_check_o    = s_q.tsync;
	assign bd_expected_toggle_o = s_q.etog;
	assign bd_count_o           = s_q.count;
	assign bd_buf_addr_o        = s_q.bufaddr;
	assign done_ready_o         = s_q.done_ready;
	assign usb_irq_o            = s_q.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_stall_seen;
		stall_sent_i && s_q.sen[FL_STALL] && !(wr_go && paddr_i == ADDR_SEN);
	endsequence

	sequence s_enable_kept;
		!(wr_go && paddr_i == ADDR_SEN);
	endsequence

	property p_irq_path;
		@(posedge clk_i) disable iff (rst_i)
		s_stall_seen ##1 s_enable_kept |=> usb_irq_o;
	endproperty
	a_irq_path: assert property (p_irq_path) else $error("enabled stall event did not raise irq");
	property p_ptr_rst;
		@(posedge clk_i) disable iff (rst_i)
		s_q.ptr_rst |=> (s_q.ptr == '0);
	endproperty
	a_ptr_rst: assert property (p_ptr_rst) else $error("pointer reset left a pointer odd");
	property p_enable_clear;
		@(posedge clk_i) disable iff (rst_i)
		(wr_go && paddr_i == ADDR_CONFIG && pwdata_i[CFG_ENABLE] && !s_q.enable) |=> (s_q.ptr == '0);
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable did not clear pointers");
	property p_toggle;
		@(posedge clk_i) disable iff (rst_i)
		(done_take && done_map[5] && !ptr_clear) |=> (s_q.ptr[$past(done_key)] != $past(s_q.ptr[done_key]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pointer did not toggle on completion");
	property p_single;
		@(posedge clk_i) disable iff (rst_i)
		(done_take && !done_map[5] && !ptr_clear) |=> (s_q.ptr[$past(done_key)] == $past(s_q.ptr[done_key]));
	endproperty
	a_single: assert property (p_single) else $error("single descriptor pointer toggled");
	property p_pid_written;
		@(posedge clk_i) disable iff (rst_i)
		done_take |=> (s_q.bd[$past(done_map[4:0])][5:2] == $past(done_pid_i))
			&& !s_q.bd[$past(done_map[4:0])][ST_OWN];
	endproperty
	a_pid_written: assert property (p_pid_written) else $error("completion did not write PID");
	property p_err_agg;
		@(posedge clk_i) disable iff (rst_i)
		(|(s_q.eflag & s_q.een)) |=> s_q.sflag[FL_ERR];
	endproperty
	a_err_agg: assert property (p_err_agg) else $error("enabled error did not set aggregate");
	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		!flag_wr |=> (($past(s_q.sflag) & ~s_q.sflag & STICKY_M) == 7'h00);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status flag cleared without write");
	property p_pop;
		@(posedge clk_i) disable iff (rst_i)
		(pop && !push) |=> (s_q.cnt == $past(s_q.cnt) - CW'(1));
	endproperty
	a_pop: assert property (p_pop) else $error("clearing transaction flag did not pop");
	property p_fetch;
		@(posedge clk_i) disable iff (rst_i)
		(tok_valid_i && s_q.enable) |=> bd_valid_o && (bd_index_o == $past(tok_map[4:0]))
			&& (!bd_expected_toggle_o || bd_toggle_check_o);
	endproperty
	a_fetch: assert property (p_fetch) else $error("descriptor fetch wrong");

endmodule

`default_nettype wire

// *** verilog/usb_pp_pkg.sv ***
/*
 * Shared constants for the USB descriptor ping-pong and interrupt block:
 * APB register map, field positions, reset values, token codes and the
 * descriptor mapping function.
 * Assumes a 32-bit APB with word-aligned registers.
 */
`default_nettype none

package usb_pp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_EP   = 8;
	localparam int NUM_BD   = 32;
	localparam int BD_BYTES = 4;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CONFIG   = 12'h000;
	localparam logic [11:0] ADDR_XFER_ST  = 12'h004;
	localparam logic [11:0] ADDR_SFLAG    = 12'h008;
	localparam logic [11:0] ADDR_SEN      = 12'h00c;
	localparam logic [11:0] ADDR_EFLAG    = 12'h010;
	localparam logic [11:0] ADDR_EEN      = 12'h014;
	localparam logic [11:0] ADDR_IRQ_ST   = 12'h018;
	localparam logic [4:0]  BD_REGION     = 5'h02;   // paddr[11:7]: 0x100..0x17c

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PTR_RST  = 2;
	localparam int CFG_ENABLE   = 3;
	localparam int FL_RESET     = 0;
	localparam int FL_ERR       = 1;
	localparam int FL_ACTIVITY  = 2;
	localparam int FL_TRN       = 3;
	localparam int FL_IDLE      = 4;
	localparam int FL_STALL     = 5;
	localparam int FL_SOF       = 6;
	localparam int ST_OWN       = 7;
	localparam int ST_ETOG      = 6;
	localparam int ST_TSYNC     = 3;
	localparam int ST_BUFFER_STALL_ENABLE    = 2;
	localparam int XS_ODD       = 1;
	localparam int XS_DIR       = 2;
	localparam int XS_EP_LSB    = 3;

	// ----------------------------------------------------------------
	// Reset values and token codes
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_REG    = 32'h0000_0000;
	localparam logic [6:0]  STICKY_M   = 7'h75;    // flags cleared only by software
	localparam logic [3:0]  PID_OUT    = 4'h1;
	localparam logic [3:0]  PID_IN     = 4'h9;
	localparam logic [3:0]  PID_SETUP  = 4'hd;

	typedef enum logic [1:0] {PP_NONE, PP_EP0_OUT, PP_ALL, PP_ALL_BUT_EP0} pp_mode_t;

	// Returns {two_descriptors, descriptor_index}
	function automatic logic [5:0] bd_map(pp_mode_t m, logic [2:0] ep, logic din, logic odd);
		logic [4:0] e4;
		logic [4:0] idx;
		logic       pp;
		e4  = {ep, 2'b00};
		idx = 5'h00;
		pp  = 1'b0;
		unique case (m)
			PP_NONE:
			begin
				idx = {1'b0, ep, din};
			end
			PP_EP0_OUT:
			begin
				if (ep == 3'h0)
				begin
					pp  = ~din;
					idx = din ? 5'h02 : {4'h0, odd};
				end
				else
					idx = {1'b0, ep, 1'b0} + 5'h01 + {4'h0, din};
			end
			PP_ALL:
			begin
				pp  = 1'b1;
				idx = e4 + {3'h0, din, odd};
			end
			PP_ALL_BUT_EP0:
			begin
				if (ep == 3'h0)
					idx = {4'h0, din};
				else
				begin
					pp  = 1'b1;
					idx = e4 - 5'h02 + {3'h0, din, odd};
				end
			end
		endcase
		return {pp, idx};
	endfunction

endpackage

`default_nettype wire

// *** verif/usb_engine_model.sv ***
/*
 * Stand-in for the serial engine: issues tokens, completions and events.
 * Assumes the block's clock and its completion-ready level.
 */
`timescale 1ns/1ps
`default_nettype none

module usb_engine_model
(
	input  wire logic        clk_i,   // Clock
	input  wire logic        ready_i, // Completion accepted
	output logic             tok_o,   // Token pulse
	output logic [2:0]       ep_o,    // Endpoint
	output logic             in_o,    // Direction IN
	output logic             done_o,  // Completion pulse
	output logic [3:0]       pid_o,   // Token PID
	output logic [9:0]       cnt_o,   // Bytes moved
	output logic [12:0]      ev_o,    // Error events and status events
	output logic             hung_o   // Ready wait ran out
);
	initial
	begin
		{tok_o, done_o, in_o, hung_o} = 4'h0;
		ep_o = 3'h0;
		pid_o = 4'h0;
		cnt_o = 10'h000;
		ev_o = 13'h0000;
	end

	// ----------------------------------------------------------------
	// Transfers and events; released transfer fields show the inverse of the last value, events go back to zero
	// ----------------------------------------------------------------
	task automatic fetch(input logic [2:0] ep, input logic din);
		@(posedge clk_i);
		tok_o <= 1'b1;
		ep_o  <= ep;
		in_o  <= din;
		@(posedge clk_i);
		tok_o <= 1'b0;
		ep_o  <= ~ep;
		in_o  <= ~din;
	endtask

	task automatic complete(input logic [2:0] ep, input logic din, input logic [3:0] pid, input logic [9:0] cnt);
		int n;
		n = 0;
		@(posedge clk_i);
		while (ready_i !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		hung_o <= hung_o | (n >= 50);
		done_o <= 1'b1;
		ep_o   <= ep;
		in_o   <= din;
		pid_o  <= pid;
		cnt_o  <= cnt;
		@(posedge clk_i);
		done_o <= 1'b0;
		ep_o   <= ~ep;
		in_o   <= ~din;
		pid_o  <= ~pid;
		cnt_o  <= ~cnt;
		@(posedge clk_i);
	endtask

	task automatic pulse(input logic [12:0] v);
		@(posedge clk_i);
		ev_o <= v;
		@(posedge clk_i);
		ev_o <= 13'h0000;
	endtask
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Self-checking bench: APB master, engine model, mapping, ping-pong and
 * interrupt scenarios. Assumes the package and the block's APB map.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import usb_pp_pkg::*;

	logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [3:0]  pstrb_i, pid;
	logic        tok, din, done, rdy, hung, e, bd_valid_o, bd_owned_o, bd_stall_o, tchk, etog, usb_irq_o;
	logic [2:0]  ep;
	logic [9:0]  cnt, bd_count_o;
	logic [12:0] ev;
	logic [4:0]  bd_index_o;
	logic [6:0]  bd_byte_addr_o;
	logic [15:0] bd_buf_addr_o;
	int          miscompares = 0;
	int          checked = 0;

	usb_pingpong_bd_irq #(.DEPTH(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.tok_valid_i(tok), .tok_ep_i(ep), .tok_in_i(din), .bd_valid_o(bd_valid_o),
		.bd_index_o(bd_index_o), .bd_byte_addr_o(bd_byte_addr_o), .bd_owned_o(bd_owned_o),
		.bd_stall_o(bd_stall_o), .bd_toggle_check_o(tchk), .bd_expected_toggle_o(etog),
		.bd_count_o(bd_count_o), .bd_buf_addr_o(bd_buf_addr_o), .done_valid_i(done),
		.done_ep_i(ep), .done_in_i(din), .done_pid_i(pid), .done_count_i(cnt), .done_ready_o(rdy),
		.sof_i(ev[0]), .stall_sent_i(ev[1]), .idle_i(ev[2]), .activity_i(ev[3]),
		.bus_reset_i(ev[4]), .err_event_i(ev[12:5]), .usb_irq_o(usb_irq_o));

	usb_engine_model i_eng (.clk_i(clk_i), .ready_i(rdy), .tok_o(tok), .ep_o(ep), .in_o(din),
		.done_o(done), .pid_o(pid), .cnt_o(cnt), .ev_o(ev), .hung_o(hung));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i    <= 1'b1;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20)
		begin
			chk("pready", 1, 0);
			stop_test();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, x, q);
	endtask

	task automatic fchk(input logic [2:0] p, input logic d, input logic v, input logic [4:0] x);
		i_eng.fetch(p, d);
		@(posedge clk_i);
		chk("bd_valid", v, bd_valid_o);
		if (v)
		begin
			chk("bd_index", x, bd_index_o);
			chk("bd_byte_addr", {x, 2'b00}, bd_byte_addr_o);
		end
	endtask

	task automatic irq(input logic x);
		repeat (3) @(posedge clk_i);
		chk("irq", x, usb_irq_o);
	endtask

	function automatic logic [4:0] exp_idx(input int m, input int p, input int d);
		int r;
		case (m)
			0: r = 2 * p + d;
			1: r = (p == 0) ? 2 * d : 2 * p + 1 + d;
			2: r = 4 * p + 2 * d;
			default: r = (p == 0) ? d : 4 * p - 2 + 2 * d;
		endcase
		return r[4:0];
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 7; i++)
			rd("reg_reset", 12'(4 * i), 0);
		rd("bd_reset", 12'h17c, 0);
		rd("unmapped", 12'h01c, 0);
		chk("slverr", 1, e);
		fchk(3'h1, 1'b0, 1'b0, 5'h00);
	endtask

	task automatic t_map();
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, ADDR_CONFIG, 32'(m));
			apb(1'b1, ADDR_CONFIG, 32'(8 + m));
			for (int k = 0; k < 16; k++)
				fchk(3'(k / 2), k[0], 1'b1, exp_idx(m, k / 2, k % 2));
		end
	endtask

	task automatic t_pingpong();
		apb(1'b1, ADDR_CONFIG, 32'ha);
		apb(1'b1, 12'h110, 32'h3412_10cc);
		apb(1'b1, 12'h114, 32'h0000_0040);
		fchk(3'h1, 1'b0, 1'b1, 5'h04);
		chk("owned", 1, bd_owned_o);
		chk("stall", 1, bd_stall_o);
		chk("etog", 1, etog);
		chk("count", 10'h010, bd_count_o);
		chk("buf", 16'h3412, bd_buf_addr_o);
		i_eng.complete(3'h1, 1'b0, PID_OUT, 10'h123);
		rd("bd_after", 12'h110, 32'h3412_2345);
		rd("xfer", ADDR_XFER_ST, 32'h8);
		fchk(3'h1, 1'b0, 1'b1, 5'h05);
		chk("tchk", 0, tchk);
		chk("etog_off", 0, etog);
		i_eng.complete(3'h1, 1'b0, PID_OUT, 10'h001);
		apb(1'b1, ADDR_SFLAG, 0);
		rd("xfer_odd", ADDR_XFER_ST, 32'ha);
		rd("trn_kept", ADDR_SFLAG, 32'h8);
		apb(1'b1, ADDR_SFLAG, 0);
		rd("xfer_empty", ADDR_XFER_ST, 0);
		fchk(3'h1, 1'b0, 1'b1, 5'h04);
		fchk(3'h1, 1'b1, 1'b1, 5'h06);
		i_eng.complete(3'h1, 1'b0, PID_OUT, 10'h001);
		apb(1'b1, ADDR_CONFIG, 32'he);
		apb(1'b1, ADDR_CONFIG, 32'ha);
		fchk(3'h1, 1'b0, 1'b1, 5'h04);
		apb(1'b1, ADDR_SFLAG, 0);
		i_eng.complete(3'h1, 1'b0, 4'h2, 10'h001);
		rd("no_queue", ADDR_XFER_ST, 0);
		apb(1'b1, ADDR_CONFIG, 32'h3);
		apb(1'b1, ADDR_CONFIG, 32'hb);
		apb(1'b1, ADDR_SEN, 32'h08);
		i_eng.complete(3'h0, 1'b0, PID_OUT, 10'h001);
		irq(1);
		fchk(3'h0, 1'b0, 1'b1, 5'h00);
		apb(1'b1, ADDR_SFLAG, 0);
		irq(0);
		apb(1'b1, ADDR_CONFIG, 32'h9);
		i_eng.complete(3'h0, 1'b0, PID_OUT, 10'h001);
		fchk(3'h0, 1'b0, 1'b1, 5'h01);
		repeat (3) i_eng.complete(3'h2, 1'b1, PID_IN, 10'h001);
		chk("done_ready_full", 0, rdy);
		repeat (4) apb(1'b1, ADDR_SFLAG, 0);
		@(posedge clk_i);
		chk("done_ready_free", 1, rdy);
	endtask

	task automatic t_irq();
		apb(1'b1, ADDR_SEN, 0);
		i_eng.pulse(13'h001f);
		rd("flags", ADDR_SFLAG, 32'h75);
		irq(0);
		apb(1'b1, ADDR_SEN, 32'h01);
		irq(1);
		rd("irq_st", ADDR_IRQ_ST, 1);
		apb(1'b1, ADDR_SFLAG, 0);
		irq(0);
		apb(1'b1, ADDR_SFLAG, 32'h22);
		rd("sw_set", ADDR_SFLAG, 32'h20);
		i_eng.pulse(13'h0100);
		rd("eflag", ADDR_EFLAG, 32'h08);
		rd("agg_off", ADDR_SFLAG, 32'h20);
		apb(1'b1, ADDR_EEN, 32'h08);
		apb(1'b1, ADDR_SEN, 32'h02);
		rd("agg_on", ADDR_SFLAG, 32'h22);
		irq(1);
		apb(1'b1, ADDR_SFLAG, 0);
		rd("agg_kept", ADDR_SFLAG, 32'h02);
		apb(1'b1, ADDR_EFLAG, 0);
		irq(0);
		apb(1'b1, ADDR_SEN, 32'h20);
		i_eng.pulse(13'h0002);
		irq(1);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial
	begin
		rst_i = 1'b1;
		{psel_i, penable_i, pwrite_i} = 3'b000;
		paddr_i = 12'h000;
		pwdata_i = 32'h0000_0000;
		pstrb_i = 4'hf;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_map();
		t_pingpong();
		t_irq();
		chk("engine_wait", 0, hung);
		stop_test();
	end
endmodule

`default_nettype wire
